// >>> rtl/hwico_overlay.sv
// Module: icon overlay with APB registers, fetch control, fade and blend on the primary path
`timescale 1ns/1ns
`default_nettype none
module hwico_overlay #(
  parameter int FIFO_DEPTH = 64,
  parameter int LEN_W      = 8
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [12:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Display timing of the primary path
  input  wire logic              frame_start_in,
  input  wire logic [10:0]       hpos_in,
  input  wire logic [10:0]       vpos_in,
  // Pixels
  input  wire logic [29:0]       gfx_pixel_in,
  input  wire logic [29:0]       sec_pixel_in,
  input  wire logic [31:0]       icon_pixel_in,
  output logic                   icon_pop_out,
  output logic [29:0]            pix_out,
  output logic [29:0]            sec_pix_out,
  // Icon memory fetch
  input  wire logic [7:0]        fifo_level_in,
  input  wire logic              mem_ack_in,
  output logic                   mem_req_out,
  output logic                   mem_req_hi_out,
  output logic [28:0]            mem_addr_out,
  output logic [1:0]             mem_tgt_out,
  // Fifth video window controls
  input  wire logic [LEN_W-1:0]  v5_len_in,
  output logic [LEN_W-1:0]       v5_len_out,
  output logic                   v5_scale_en_out
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [29:0] color_mask(input logic [1:0] fmt);
    case (fmt)
      hwico_pkg::FMT_RGB555: color_mask = 30'h00007FFF;
      hwico_pkg::FMT_RGB565: color_mask = 30'h0000FFFF;
      hwico_pkg::FMT_RGB32:  color_mask = 30'h00FFFFFF;
      default:               color_mask = 30'h3FFFFFFF;
    endcase
  endfunction

  function automatic logic [9:0] blend_ch(input logic [9:0] ic, input logic [9:0] gf,
                                          input logic [7:0] a, input logic add_mode);
    logic [17:0] gpart;
    logic [17:0] ipart;
    logic [10:0] sum;
    gpart = {10'h000, 8'hFF - a} * {8'h00, gf};
    ipart = {10'h000, a} * {8'h00, ic};
    if (add_mode) begin
      sum = {1'b0, ic} + {1'b0, gpart[17:8]};
    end else begin
      sum = {1'b0, ipart[17:8]} + {1'b0, gpart[17:8]};
    end
    blend_ch = sum[10] ? 10'h3FF : sum[9:0];
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] fifo_thr_r;
  logic [31:0] transp_r;
  logic [31:0] ctrl_r;
  logic [31:0] fb_start_r;
  logic [31:0] start_loc_r;
  logic [31:0] center_r;
  logic [31:0] inverse_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_mux;
  logic [31:0] fifo_thr_rd;

  wire logic setup_ph  = psel_in & ~penable_in;
  wire logic access_ph = psel_in & penable_in;
  wire logic sel_thr   = paddr_in == hwico_pkg::OFS_FIFO_THR;
  wire logic sel_tr    = paddr_in == hwico_pkg::OFS_TRANSP;
  wire logic sel_ctl   = paddr_in == hwico_pkg::OFS_CTRL;
  wire logic sel_fb    = paddr_in == hwico_pkg::OFS_FB_START;
  wire logic sel_loc   = paddr_in == hwico_pkg::OFS_START_LOC;
  wire logic sel_cen   = paddr_in == hwico_pkg::OFS_CENTER;
  wire logic sel_inv   = paddr_in == hwico_pkg::OFS_INVERSE;
  wire logic mapped    = sel_thr | sel_tr | sel_ctl | sel_fb | sel_loc | sel_cen | sel_inv;
  wire logic wr_en     = access_ph & pwrite_in & mapped;
  wire logic [31:0] wd = pwdata_in;

  // Depth field is read-only and shows the FIFO size minus one
  localparam logic [7:0] DEPTH_M1 = 8'(FIFO_DEPTH - 1);
  assign fifo_thr_rd = {fifo_thr_r[31:8], DEPTH_M1};
  assign rd_mux = sel_thr ? fifo_thr_rd :
                  sel_tr  ? transp_r    :
                  sel_ctl ? ctrl_r      :
                  sel_fb  ? fb_start_r  :
                  sel_loc ? start_loc_r :
                  sel_cen ? center_r    :
                  sel_inv ? inverse_r   : 32'h00000000;

  // Zero-wait slave: read data is latched in the setup cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = access_ph & ~mapped;
  assign prdata_out  = prdata_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fifo_thr_r  <= hwico_pkg::RST_ZERO;
      transp_r    <= hwico_pkg::RST_ZERO;
      ctrl_r      <= hwico_pkg::RST_CTRL;
      fb_start_r  <= hwico_pkg::RST_ZERO;
      start_loc_r <= hwico_pkg::RST_ZERO;
      center_r    <= hwico_pkg::RST_ZERO;
      inverse_r   <= hwico_pkg::RST_ZERO;
      prdata_r    <= hwico_pkg::RST_ZERO;
    end else begin
      if (wr_en & sel_thr) fifo_thr_r  <= wd & hwico_pkg::WM_FIFO_THR;
      if (wr_en & sel_tr)  transp_r    <= wd & hwico_pkg::WM_COLOR;
      if (wr_en & sel_ctl) ctrl_r      <= wd & hwico_pkg::WM_CTRL;
      if (wr_en & sel_fb)  fb_start_r  <= wd & hwico_pkg::WM_FB_START;
      if (wr_en & sel_loc) start_loc_r <= wd & hwico_pkg::WM_LOC;
      if (wr_en & sel_cen) center_r    <= wd & hwico_pkg::WM_CENTER;
      if (wr_en & sel_inv) inverse_r   <= wd & hwico_pkg::WM_COLOR;
      if (setup_ph & ~pwrite_in) prdata_r <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  wire logic       icon_en   = ctrl_r[hwico_pkg::CB_ICON_EN];
  wire logic       blend_en  = ctrl_r[hwico_pkg::CB_BLEND_EN];
  wire logic       add_mode  = ctrl_r[hwico_pkg::CB_ADD_MODE];
  wire logic       alpha_src = ctrl_r[hwico_pkg::CB_ALPHA_SRC];
  wire logic       prefetch  = ctrl_r[hwico_pkg::CB_PREFETCH];
  wire logic       fade_en   = ctrl_r[hwico_pkg::CB_FADE_EN];
  wire logic       fade_in   = ctrl_r[hwico_pkg::CB_FADE_DIR];
  wire logic [1:0] fmt       = ctrl_r[hwico_pkg::CB_FMT +: 2];
  wire logic [1:0] size_sel  = ctrl_r[hwico_pkg::CB_SIZE +: 2];
  wire logic [3:0] step      = ctrl_r[hwico_pkg::CB_STEP +: 4];
  wire logic [7:0] const_alpha = {ctrl_r[hwico_pkg::CB_ALPHA_HI +: 4],
                                  ctrl_r[hwico_pkg::CB_ALPHA_LO +: 4]};
  wire logic [1:0] tgt       = fb_start_r[hwico_pkg::FB_TGT_POS +: 2];
  wire logic [7:0] pre_thr   = fifo_thr_r[31:24];
  wire logic [7:0] prio_thr  = fifo_thr_r[15:8];

  assign v5_len_out = ctrl_r[hwico_pkg::CB_V5_LEN_DIS] ? '0 : v5_len_in;
  assign v5_scale_en_out = ctrl_r[hwico_pkg::CB_V5_SCALE];

  // ---------------------------------------------------------------
  // Window placement
  // ---------------------------------------------------------------
  logic [10:0] icon_size;
  assign icon_size = (size_sel == 2'h0) ? hwico_pkg::SIZE_32 :
                     (size_sel == 2'h1) ? hwico_pkg::SIZE_64 : hwico_pkg::SIZE_128;

  // Origin is the start location minus the centre offset (hot spot)
  wire logic [10:0] x0 = start_loc_r[hwico_pkg::LOC_X_POS +: 11]
                         - {4'h0, center_r[22:16]};
  wire logic [10:0] y0 = start_loc_r[10:0] - {4'h0, center_r[6:0]};
  wire logic [10:0] dx = hpos_in - x0;
  wire logic [10:0] dy = vpos_in - y0;
  wire logic in_cols = (hpos_in >= x0) & (dx < icon_size);
  wire logic in_rows = (vpos_in >= y0) & (dy < icon_size);
  wire logic in_win  = icon_en & in_cols & in_rows;
  assign icon_pop_out = in_win;

  // ---------------------------------------------------------------
  // Fetch control
  // ---------------------------------------------------------------
  logic [24:0] fetch_addr_r;
  wire logic pre_line = prefetch & (vpos_in == y0 - 11'h001);
  wire logic fetch_active = icon_en & (tgt != hwico_pkg::TGT_RSVD)
                            & (in_rows | pre_line);
  assign mem_req_out    = fetch_active & (fifo_level_in <= pre_thr);
  assign mem_req_hi_out = mem_req_out & (fifo_level_in <= prio_thr);
  assign mem_addr_out   = {fetch_addr_r, 4'h0};
  assign mem_tgt_out    = tgt;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_addr_r <= 25'h0000000;
    end else if (frame_start_in) begin
      fetch_addr_r <= fb_start_r[28:hwico_pkg::FB_UNIT_SH];
    end else if (mem_req_out & mem_ack_in) begin
      fetch_addr_r <= fetch_addr_r + 25'h0000001;
    end
  end

  // ---------------------------------------------------------------
  // Per-frame fade
  // ---------------------------------------------------------------
  logic [7:0] frame_alpha_r;
  logic [7:0] frame_alpha_nxt;
  assign frame_alpha_nxt = fade_in ? frame_alpha_r + {4'h0, step}
                                   : frame_alpha_r - {4'h0, step};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_alpha_r <= 8'hFF;
    end else if (!fade_en) begin
      frame_alpha_r <= const_alpha;
    end else if (frame_start_in) begin
      frame_alpha_r <= frame_alpha_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pixel decode and compose
  // ---------------------------------------------------------------
  logic [29:0] icon_rgb;
  always_comb begin
    case (fmt)
      hwico_pkg::FMT_RGB555: icon_rgb = {icon_pixel_in[14:10], icon_pixel_in[14:10],
                                         icon_pixel_in[9:5], icon_pixel_in[9:5],
                                         icon_pixel_in[4:0], icon_pixel_in[4:0]};
      hwico_pkg::FMT_RGB565: icon_rgb = {icon_pixel_in[15:11], icon_pixel_in[15:11],
                                         icon_pixel_in[10:5], icon_pixel_in[10:7],
                                         icon_pixel_in[4:0], icon_pixel_in[4:0]};
      hwico_pkg::FMT_RGB32:  icon_rgb = {icon_pixel_in[23:16], icon_pixel_in[23:22],
                                         icon_pixel_in[15:8], icon_pixel_in[15:14],
                                         icon_pixel_in[7:0], icon_pixel_in[7:6]};
      default:               icon_rgb = icon_pixel_in[29:0];
    endcase
  end

  wire logic [29:0] cmask   = color_mask(fmt);
  wire logic is_transp = (icon_pixel_in[29:0] & cmask) == (transp_r[29:0] & cmask);
  wire logic is_invert = (icon_pixel_in[29:0] & cmask) == (inverse_r[29:0] & cmask);
  wire logic true_color = fmt[1];
  // Fade resolves only the upper nibble; it is replicated to span full range
  wire logic [7:0] base_alpha = fade_en ? {frame_alpha_r[7:4], frame_alpha_r[7:4]}
                                        : const_alpha;
  wire logic [7:0] pix_alpha  = alpha_src ? icon_pixel_in[31:24]
                                          : icon_pixel_in[23:16];
  wire logic [7:0] eff_alpha  = true_color ? pix_alpha : base_alpha;

  logic [29:0] blended;
  assign blended = {blend_ch(icon_rgb[29:20], gfx_pixel_in[29:20], eff_alpha, add_mode),
                    blend_ch(icon_rgb[19:10], gfx_pixel_in[19:10], eff_alpha, add_mode),
                    blend_ch(icon_rgb[9:0],   gfx_pixel_in[9:0],   eff_alpha, add_mode)};

  logic [29:0] composed;
  assign composed = !in_win   ? gfx_pixel_in :
                    is_transp ? gfx_pixel_in :
                    is_invert ? ~gfx_pixel_in :
                    blend_en  ? blended : icon_rgb;

  logic [29:0] pix_r;
  logic [29:0] sec_pix_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pix_r     <= 30'h00000000;
      sec_pix_r <= 30'h00000000;
    end else begin
      pix_r     <= composed;
      sec_pix_r <= sec_pixel_in;
    end
  end
  assign pix_out     = pix_r;
  assign sec_pix_out = sec_pix_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence fade_tick_s;
    fade_en & frame_start_in;
  endsequence
  sequence ctrl_write_s;
    wr_en & sel_ctl;
  endsequence

  early_req_a: assert property ((in_win & (tgt != hwico_pkg::TGT_RSVD)
      & (fifo_level_in <= pre_thr)) |-> mem_req_out)
    else $error("early request missing at pre-threshold");
  high_prio_a: assert property (mem_req_hi_out |-> (fifo_level_in <= prio_thr) & mem_req_out)
    else $error("high priority without reaching threshold");
  fade_step_a: assert property (fade_tick_s ##1 fade_en
      |-> frame_alpha_r == ($past(fade_in) ? $past(frame_alpha_r) + {4'h0, $past(step)}
                                           : $past(frame_alpha_r) - {4'h0, $past(step)}))
    else $error("fade step wrong");
  fade_hold_a: assert property ((!fade_en & !$past(wr_en & sel_ctl)) ##1 !fade_en
      |-> frame_alpha_r == $past(const_alpha))
    else $error("alpha moved with fade disabled");
  v5_len_a: assert property (ctrl_r[hwico_pkg::CB_V5_LEN_DIS] |-> v5_len_out == '0)
    else $error("fifth window length not forced to zero");
  rsvd_tgt_a: assert property ((tgt == hwico_pkg::TGT_RSVD) |-> !mem_req_out)
    else $error("request to reserved target");
  transp_pass_a: assert property ((in_win & is_transp) |=> pix_out == $past(gfx_pixel_in))
    else $error("transparent pixel altered graphics");
  icon_off_a: assert property (!icon_en |-> !icon_pop_out ##1 (pix_out == $past(gfx_pixel_in)))
    else $error("icon shown while disabled");
  sec_path_a: assert property (1'b1 |=> sec_pix_out == $past(sec_pixel_in))
    else $error("secondary path touched");
  ctrl_rd_a: assert property (ctrl_write_s ##[1:4] (setup_ph & ~pwrite_in & sel_ctl)
      |=> prdata_out == $past(ctrl_r))
    else $error("control readback wrong");
  size_a: assert property ((size_sel == 2'h0) |-> icon_size == hwico_pkg::SIZE_32)
    else $error("size decode wrong");
endmodule : hwico_overlay
`default_nettype wire

// >>> rtl/hwico_pkg.sv
// Package: register map, field layout, reset values and fixed sizes for the icon overlay
// ----------------------------------------------------------------------------
// How it works
// - Early fetch request rises once FIFO level falls to the pre-threshold.
// - Request priority turns high once FIFO level falls to the threshold.
// - Pre-fetch enable starts fetching one line before the icon window.
// - Blend-mode bit gives icon plus (one minus alpha) times graphics.
// - True-colour per-pixel alpha comes from bits 23:16, or 31:24 if selected.
// - Size field: 00 is 32x32, 01 is 64x64, 1x is 128x128.
// - Format field: 00 RGB555, 01 RGB565, 10 RGB32, 11 RGB10.
// - Constant alpha is high nibble 7:4 plus low nibble 19:16, reset all ones.
// - Fade changes alpha per frame by step from constant; upper nibble used.
// - Fade direction 1 adds the step; 0 subtracts it.
// - Alpha fade runs only while fade enable is set.
// - Fifth video window length disable forces that window's request length zero.
// - Scaling bit enables fifth video window scaling on the primary path.
// - Icon shows only when enabled; blends with graphics only when blending enabled.
// - Icon fetch starts at address from bits 28:4, in 16-byte units.
// - Fetches go to target code 00, 01 or 11; code 10 is reserved.
// - Icon starts at 11-bit horizontal pixel and vertical line positions.
// - Icon applies 7-bit horizontal and vertical centre offsets.
// - Transparent colour compares format-dependent bit ranges of the pixel.
// - Inverse colour compares the same format-dependent bit ranges.
// - Overlay acts on the primary path only; secondary path passes through.
// ----------------------------------------------------------------------------
package hwico_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [12:0] OFS_FIFO_THR   = 13'h02E8;
  localparam logic [12:0] OFS_TRANSP     = 13'h02EC;
  localparam logic [12:0] OFS_CTRL       = 13'h02F0;
  localparam logic [12:0] OFS_FB_START   = 13'h02F4;
  localparam logic [12:0] OFS_START_LOC  = 13'h02F8;
  localparam logic [12:0] OFS_CENTER     = 13'h02FC;
  localparam logic [12:0] OFS_INVERSE    = 13'h120C;
  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_CTRL       = 32'h000F00F0;
  localparam logic [31:0] RST_ZERO       = 32'h00000000;
  localparam logic [31:0] WM_FIFO_THR    = 32'hFF00FF00;
  localparam logic [31:0] WM_COLOR       = 32'h3FFFFFFF;
  localparam logic [31:0] WM_CTRL        = 32'h7F0FF3FF;
  localparam logic [31:0] WM_FB_START    = 32'h7FFFFFF0;
  localparam logic [31:0] WM_LOC         = 32'h07FF07FF;
  localparam logic [31:0] WM_CENTER      = 32'h007F007F;
  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int CB_PREFETCH   = 30;
  localparam int CB_ADD_MODE   = 29;
  localparam int CB_ALPHA_SRC  = 28;
  localparam int CB_SIZE       = 26;
  localparam int CB_FMT        = 24;
  localparam int CB_ALPHA_LO   = 16;
  localparam int CB_STEP       = 12;
  localparam int CB_FADE_DIR   = 9;
  localparam int CB_FADE_EN    = 8;
  localparam int CB_ALPHA_HI   = 4;
  localparam int CB_V5_LEN_DIS = 3;
  localparam int CB_BLEND_EN   = 2;
  localparam int CB_V5_SCALE   = 1;
  localparam int CB_ICON_EN    = 0;
  localparam int FB_TGT_POS    = 29;
  localparam int LOC_X_POS     = 16;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  FMT_RGB555 = 2'h0;
  localparam logic [1:0]  FMT_RGB565 = 2'h1;
  localparam logic [1:0]  FMT_RGB32  = 2'h2;
  localparam logic [1:0]  FMT_RGB10  = 2'h3;
  localparam logic [1:0]  TGT_RSVD   = 2'h2;
  localparam logic [10:0] SIZE_32    = 11'h020;
  localparam logic [10:0] SIZE_64    = 11'h040;
  localparam logic [10:0] SIZE_128   = 11'h080;
  localparam int          FB_UNIT_SH = 4;
endpackage : hwico_pkg

// >>> testbench/hwico_fb_model.sv
// Frame buffer side model that acknowledges icon fetch requests
`timescale 1ns/1ns
`default_nettype none
module hwico_fb_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Fetch handshake
  input  wire logic mem_req_in,
  input  wire logic slow_in,
  output logic      mem_ack_out
);
  logic [1:0] wait_r;
  // Slow mode stalls three cycles, like a busy memory
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_r      <= 2'h0;
      mem_ack_out <= 1'b0;
    end else begin
      mem_ack_out <= 1'b0;
      if (!mem_req_in || mem_ack_out) begin
        wait_r <= 2'h0;
      end else if (wait_r == (slow_in ? 2'h3 : 2'h0)) begin
        mem_ack_out <= 1'b1;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // hwico_fb_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the icon overlay
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwd = 32'h0, prd, ico = 32'h0;
  logic        prdy, perr, fs = 1'b0, pop, req, hi, ack, slow = 1'b0, scl;
  logic [10:0] hp = 11'h0, vp = 11'h0;
  logic [29:0] gfx = 30'h0, sec = 30'h0, pix, spix;
  logic [7:0]  lvl = 8'hFF, len = 8'h5A, leno;
  logic [28:0] addr;
  logic [1:0]  tgt;
  logic [32:0] exp_q[$];
  int          failures = 0, total_checks = 0, acks = 0;
  always #20 clk = ~clk;
  hwico_overlay #(.FIFO_DEPTH(64), .LEN_W(8)) dut_u (
    .clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .frame_start_in(fs), .hpos_in(hp), .vpos_in(vp),
    .gfx_pixel_in(gfx), .sec_pixel_in(sec), .icon_pixel_in(ico), .icon_pop_out(pop),
    .pix_out(pix), .sec_pix_out(spix), .fifo_level_in(lvl), .mem_ack_in(ack),
    .mem_req_out(req), .mem_req_hi_out(hi), .mem_addr_out(addr), .mem_tgt_out(tgt),
    .v5_len_in(len), .v5_len_out(leno), .v5_scale_en_out(scl));
  hwico_fb_model fb_u (.clk_in(clk), .rst_in(rst), .mem_req_in(req), .slow_in(slow),
    .mem_ack_out(ack));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read answers are matched against the oldest noted expectation
  always @(posedge clk) begin
    if (psel && pen && prdy === 1'b1 && !pwr) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else check({perr, prd}, exp_q.pop_front());
    end
    if (ack && req) acks++;
  end
  task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwr <= wr; paddr <= a; pwd <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (n == 16) begin failures++; close_out(); end
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic px(input logic [10:0] x, input logic [10:0] y, input logic [31:0] ic,
                    input logic [29:0] g, input logic ep, input logic [29:0] e);
    logic [29:0] s;
    s = 30'($urandom);
    @(posedge clk);
    hp <= x; vp <= y; ico <= ic; gfx <= g; sec <= s;
    #1 if (ep !== 1'bx) check(33'(pop), 33'(ep));
    @(posedge clk);
    #1 check(33'(pix), 33'(e));
    check(33'(spix), 33'(s));
  endtask
  task automatic frame();
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [12:0] ofs[7];
    logic [31:0] msk[7];
    logic [31:0] d, ic;
    logic [10:0] xs[5], ys[5], sz;
    logic        ps[5];
    int          i;
    void'($urandom(41));
    ofs = '{hwico_pkg::OFS_FIFO_THR, hwico_pkg::OFS_TRANSP, hwico_pkg::OFS_CTRL,
            hwico_pkg::OFS_FB_START, hwico_pkg::OFS_START_LOC, hwico_pkg::OFS_CENTER,
            hwico_pkg::OFS_INVERSE};
    msk = '{hwico_pkg::WM_FIFO_THR, hwico_pkg::WM_COLOR, hwico_pkg::WM_CTRL,
            hwico_pkg::WM_FB_START, hwico_pkg::WM_LOC, hwico_pkg::WM_CENTER,
            hwico_pkg::WM_COLOR};
    xs = '{11'd96, 11'd127, 11'd95, 11'd128, 11'd96};
    ys = '{11'd48, 11'd79, 11'd48, 11'd48, 11'd80};
    ps = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      d = $urandom;
      apb(1'b0, ofs[i], 32'h0, {1'b0, i == 0 ? 32'h3F : i == 2 ? 32'h000F00F0 : 32'h0});
      wr(ofs[i], d);
      apb(1'b0, ofs[i], 32'h0, {1'b0, (d & msk[i]) | (i == 0 ? 32'h3F : 32'h0)});
    end
    wr(13'h0300, 32'hFFFFFFFF);
    apb(1'b0, 13'h0300, 32'h0, {1'b1, 32'h0});
    wr(hwico_pkg::OFS_CTRL, 32'h0300000B);
    #1 check(33'(leno), 33'h0);
    check(33'(scl), 33'h1);
    wr(hwico_pkg::OFS_CTRL, 32'h03000001);
    #1 check(33'(leno), 33'h5A);
    check(33'(scl), 33'h0);
    wr(hwico_pkg::OFS_START_LOC, 32'h00640032);
    wr(hwico_pkg::OFS_CENTER, 32'h00040002);
    wr(hwico_pkg::OFS_TRANSP, 32'h00012345);
    wr(hwico_pkg::OFS_INVERSE, 32'h00ABCDEF);
    for (i = 0; i < 5; i++) begin
      ic = $urandom;
      d = $urandom;
      px(xs[i], ys[i], ic, d[29:0], ps[i], ps[i] ? ic[29:0] : d[29:0]);
    end
    for (i = 1; i < 4; i++) begin
      sz = (i == 1) ? 11'd64 : 11'd128;
      wr(hwico_pkg::OFS_CTRL, 32'h03000001 | (32'(i) << 26));
      px(11'd95 + sz, 11'd48, 32'h0, 30'h0, 1'b1, 30'h0);
      px(11'd96 + sz, 11'd48, 32'h0, 30'h0, 1'b0, 30'h0);
    end
    d = $urandom;
    px(11'd96, 11'd48, 32'hC0012345, d[29:0], 1'b1, d[29:0]);
    px(11'd96, 11'd48, 32'h00ABCDEF, d[29:0], 1'b1, ~d[29:0]);
    wr(hwico_pkg::OFS_CTRL, 32'h03000000);
    px(11'd96, 11'd48, 32'h12345678, d[29:0], 1'bx, d[29:0]);
    for (i = 0; i < 3; i++) begin
      wr(hwico_pkg::OFS_CTRL, (32'(i) << 24) | 32'h00000001);
      ic = (i == 0) ? 32'h00007C00 : (i == 1) ? 32'h0000F800 : 32'h00FF0000;
      px(11'd96, 11'd48, ic, 30'h0, 1'b1, 30'h3FF00000);
    end
    wr(hwico_pkg::OFS_CTRL, 32'h02000005);
    px(11'd96, 11'd48, 32'h00FF0000, 30'h0, 1'b1, 30'h3FB00000);
    wr(hwico_pkg::OFS_CTRL, 32'h12000005);
    px(11'd96, 11'd48, 32'h00FF0000, 30'h3FFFFFFF, 1'b1, 30'h3FBFEFFB);
    wr(hwico_pkg::OFS_CTRL, 32'h32000005);
    px(11'd96, 11'd48, 32'h00FF0000, 30'h3FFFFFFF, 1'b1, 30'h3FFFEFFB);
    wr(hwico_pkg::OFS_CTRL, 32'h03000001);
    wr(hwico_pkg::OFS_FIFO_THR, 32'h20001000);
    wr(hwico_pkg::OFS_FB_START, 32'h20123450);
    @(posedge clk);
    vp <= 11'd48; lvl <= 8'h21; fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    #1 check(33'(req), 33'h0);
    check(33'(addr), 33'h0123450);
    check(33'(tgt), 33'h1);
    lvl = 8'h20;
    #1 check(33'({req, hi}), 33'h2);
    lvl = 8'h10;
    #1 check(33'({req, hi}), 33'h3);
    acks = 0;
    slow <= 1'b1;
    repeat (20) @(posedge clk);
    lvl <= 8'h21;
    repeat (6) @(posedge clk);
    #1 check(33'(acks != 0), 33'h1);
    check(33'(addr), 33'(29'h0123450 + 29'(acks * 16)));
    vp <= 11'd47; lvl <= 8'h10;
    #1 check(33'(req), 33'h0);
    wr(hwico_pkg::OFS_CTRL, 32'h43000001);
    #1 check(33'(req), 33'h1);
    wr(hwico_pkg::OFS_FB_START, 32'h40123450);
    #1 check(33'(req), 33'h0);
    wr(hwico_pkg::OFS_CTRL, 32'h01008305);
    frame();
    px(11'd96, 11'd48, 32'h0000FFFF, 30'h0, 1'b1, 30'h0);
    frame();
    px(11'd96, 11'd48, 32'h0000FFFF, 30'h0, 1'b1, 30'h04310C43);
    wr(hwico_pkg::OFS_CTRL, 32'h01008105);
    frame();
    px(11'd96, 11'd48, 32'h0000FFFF, 30'h0, 1'b1, 30'h0);
    wr(hwico_pkg::OFS_CTRL, 32'h010000F5);
    frame();
    px(11'd96, 11'd48, 32'h0000FFFF, 30'h0, 1'b1, 30'h3BFEFFBF);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
